// ===== core/esfb_map.vh
// register map, field positions, reset values and storage constants of the sram/fifo block
`ifndef ESFB_MAP_VH
`define ESFB_MAP_VH

// avalon byte offsets
`define ESFB_OFS_CTRL 4'h0
`define ESFB_OFS_STATUS 4'h4
`define ESFB_OFS_PTRS 4'h8

// control register fields
`define ESFB_CTRL_FIFO 0
`define ESFB_CTRL_WA_LSB 1
`define ESFB_CTRL_WB_LSB 4
`define ESFB_CTRL_PIPE_A 7
`define ESFB_CTRL_PIPE_B 8
`define ESFB_CTRL_CLR 9
`define ESFB_CTRL_BITS 9
`define ESFB_CTRL_RST 9'h036

// status register fields
`define ESFB_ST_EMPTY 0
`define ESFB_ST_FULL 1
`define ESFB_ST_ALMOST_EMPTY 2
`define ESFB_ST_ALMOST_FULL 3
`define ESFB_ST_LEVEL_LSB 16

// pointer register fields
`define ESFB_PTRS_WR_LSB 0
`define ESFB_PTRS_RD_LSB 16

// width select codes
`define ESFB_W1 3'h0
`define ESFB_W2 3'h1
`define ESFB_W4 3'h2
`define ESFB_W9 3'h3
`define ESFB_W18 3'h4

// storage units per element (72 units per nine-bit word)
`define ESFB_U1 8'h09
`define ESFB_U2 8'h12
`define ESFB_U4 8'h24
`define ESFB_U9 8'h48
`define ESFB_U18 8'h90
`define ESFB_CAP_UNITS 16'h9000
`define ESFB_AF_MARGIN 16'h0090
`define ESFB_AE_MARGIN 16'h0090

// array shape: 512 words of 9 bits
`define ESFB_WORDS 512
`define ESFB_WORD_BITS 9

`endif

// ===== core/esfb_port.v
// one memory port: address to word and lane mapping, write lanes, read pipeline
`timescale 1ns/100ps
`default_nettype none
`include "esfb_map.vh"
module esfb_port (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // configuration
  input wire [2:0] width,
  input wire pipe_sel,
  // access
  input wire [11:0] addr,
  input wire [17:0] wdata,
  input wire rd_en,
  // array side
  input wire [8:0] rword0,
  input wire [8:0] rword1,
  output reg [8:0] word0,
  output reg [8:0] word1,
  output reg two_words,
  output reg [8:0] mask0,
  output reg [8:0] data0,
  output wire [8:0] mask1,
  output wire [8:0] data1,
  // read data
  output reg [17:0] rdata
);

reg [3:0] shift;
reg [8:0] lane;
reg [17:0] ext;
reg [17:0] stage_q;
reg pend_q;
wire [8:0] shifted;

////////////////////////////////////////////////////////////////
// narrow widths pack into the low eight bits, low address first
always @* begin
  word1 = {addr[7:0], 1'b1};
  two_words = 1'b0;
  case (width)
    `ESFB_W1: begin
      word0 = addr[11:3];
      shift = {1'b0, addr[2:0]};
      lane = 9'h001;
    end
    `ESFB_W2: begin
      word0 = addr[10:2];
      shift = {1'b0, addr[1:0], 1'b0};
      lane = 9'h003;
    end
    `ESFB_W4: begin
      word0 = addr[9:1];
      shift = {1'b0, addr[0], 2'b00};
      lane = 9'h00F;
    end
    `ESFB_W18: begin
      word0 = {addr[7:0], 1'b0};
      shift = 4'h0;
      lane = 9'h1FF;
      two_words = 1'b1;
    end
    default: begin
      word0 = addr[8:0];
      shift = 4'h0;
      lane = 9'h1FF;
    end
  endcase
  mask0 = lane << shift;
  data0 = (wdata[8:0] & lane) << shift;
end

assign mask1 = two_words ? 9'h1FF : 9'h000;
assign data1 = wdata[17:9];
assign shifted = rword0 >> shift;

// ninth bit unreachable at narrow widths; read as 9 after 4-bit writes is undefined
always @* begin
  if (two_words) begin
    ext = {rword1, rword0};
  end else begin
    ext = {9'h000, shifted & lane};
  end
end

////////////////////////////////////////////////////////////////
// read registered on the clock; pipelined adds one cycle
always @(posedge clk) begin
  if (!rst_n) begin
    stage_q <= 18'h00000;
    pend_q <= 1'b0;
    rdata <= 18'h00000;
  end else begin
    pend_q <= rd_en;
    if (rd_en) begin
      stage_q <= ext;
    end
    // no read, no change: a disabled port holds its output
    if (!pipe_sel && rd_en) begin
      rdata <= ext;
    end else if (pipe_sel && pend_q) begin
      rdata <= stage_q;
    end
  end
end

endmodule // esfb_port
`default_nettype wire

// ===== core/esfb_fifo_ctrl.v
// hardwired fifo controller: address counters, fill level and flags
`timescale 1ns/100ps
`default_nettype none
`include "esfb_map.vh"
module esfb_fifo_ctrl #(
  parameter [15:0] AF_MARGIN = `ESFB_AF_MARGIN,
  parameter [15:0] AE_MARGIN = `ESFB_AE_MARGIN
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  input wire clear,
  // configuration
  input wire [2:0] wr_width,
  input wire [2:0] rd_width,
  // requests
  input wire push_req,
  input wire pop_req,
  output wire push_ok,
  output wire pop_ok,
  // addresses and flags
  output reg [11:0] waddr_q,
  output reg [11:0] raddr_q,
  output reg [15:0] level_q,
  output wire full,
  output wire empty,
  output wire almost_full_flag,
  output wire almost_empty_flag
);

function [7:0] units;
  input [2:0] w;
  begin
    case (w)
      `ESFB_W1: units = `ESFB_U1;
      `ESFB_W2: units = `ESFB_U2;
      `ESFB_W4: units = `ESFB_U4;
      `ESFB_W18: units = `ESFB_U18;
      default: units = `ESFB_U9;
    endcase
  end
endfunction

function [11:0] dmask;
  input [2:0] w;
  begin
    case (w)
      `ESFB_W1: dmask = 12'hFFF;
      `ESFB_W2: dmask = 12'h7FF;
      `ESFB_W4: dmask = 12'h3FF;
      `ESFB_W18: dmask = 12'h0FF;
      default: dmask = 12'h1FF;
    endcase
  end
endfunction

wire [15:0] wu;
wire [15:0] ru;
wire [16:0] after_push;

assign wu = {8'h00, units(wr_width)};
assign ru = {8'h00, units(rd_width)};
assign after_push = {1'b0, level_q} + {1'b0, wu};

// flags in common storage units, so unequal widths compare fairly
assign full = after_push > {1'b0, `ESFB_CAP_UNITS};
assign empty = level_q < ru;
assign almost_full_flag = level_q >= (`ESFB_CAP_UNITS - AF_MARGIN);
assign almost_empty_flag = level_q <= AE_MARGIN;
assign push_ok = push_req & ~full;
assign pop_ok = pop_req & ~empty;

////////////////////////////////////////////////////////////////
// each side steps one word of its own width
always @(posedge clk) begin
  if (!rst_n || clear) begin
    waddr_q <= 12'h000;
    raddr_q <= 12'h000;
    level_q <= 16'h0000;
  end else begin
    if (push_ok) begin
      waddr_q <= (waddr_q + 12'h001) & dmask(wr_width);
    end
    if (pop_ok) begin
      raddr_q <= (raddr_q + 12'h001) & dmask(rd_width);
    end
    level_q <= level_q + (push_ok ? wu : 16'h0000) - (pop_ok ? ru : 16'h0000);
  end
end

endmodule // esfb_fifo_ctrl
`default_nettype wire

// ===== core/esfb_top.v
// embedded 4608-bit sram block with two ports, fifo controller and avalon control
//
// Register access over Avalon-MM and the placing of the registers are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
`include "esfb_map.vh"
module esfb_top #(
  parameter [15:0] AF_MARGIN = `ESFB_AF_MARGIN,
  parameter [15:0] AE_MARGIN = `ESFB_AE_MARGIN
) (
  // clock and reset
  input wire clk,
  input wire rst_n,
  // avalon-mm slave
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output reg [31:0] avs_readdata,
  output wire avs_waitrequest,
  // port a
  input wire port_a_block_enable_n,
  input wire port_a_write_select_n,
  input wire [11:0] port_a_addr,
  input wire [17:0] port_a_wdata,
  output wire [17:0] port_a_rdata,
  // port b
  input wire port_b_block_enable_n,
  input wire port_b_write_select_n,
  input wire [11:0] port_b_addr,
  input wire [17:0] port_b_wdata,
  output wire [17:0] port_b_rdata,
  // fifo flags
  output wire fifo_full,
  output wire fifo_empty,
  output wire almost_full_flag,
  output wire almost_empty_flag
);

reg [`ESFB_CTRL_BITS-1:0] ctrl_q;
reg clear_q;
reg ack_q;
reg [8:0] mem_q [0:`ESFB_WORDS-1];
wire [`ESFB_WORDS*`ESFB_WORD_BITS-1:0] mem_d;
integer k;

wire fifo_mode;
wire [2:0] write_width_select;
wire [2:0] width_b;
wire port_a_read_pipeline_sel;
wire port_b_read_pipeline_sel;
wire a_en;
wire b_en;
wire a_wr;
wire b_wr;
wire a_rd;
wire b_rd;
wire push_ok;
wire pop_ok;
wire [11:0] fifo_waddr;
wire [11:0] fifo_raddr;
wire [15:0] fifo_level;
wire [11:0] a_addr_sel;
wire [11:0] b_addr_sel;
wire [8:0] a_w0;
wire [8:0] a_w1;
wire [8:0] b_w0;
wire [8:0] b_w1;
wire a_two;
wire b_two;
wire [8:0] a_m0;
wire [8:0] a_d0;
wire [8:0] a_m1;
wire [8:0] a_d1;
wire [8:0] b_m0;
wire [8:0] b_d0;
wire [8:0] b_m1;
wire [8:0] b_d1;
wire bus_req;
wire bus_take;
wire ctrl_hit;
wire rd_load;
wire fifo_clear;
wire push_req;
wire pop_req;
wire [31:0] ctrl_word;
reg [31:0] ptrs_word;
reg [31:0] status_word;
reg [31:0] rd_mux;

////////////////////////////////////////////////////////////////
// control fields; widths per side are independent
assign fifo_mode = ctrl_q[`ESFB_CTRL_FIFO];
assign write_width_select = ctrl_q[`ESFB_CTRL_WA_LSB +: 3];
assign width_b = ctrl_q[`ESFB_CTRL_WB_LSB +: 3];
assign port_a_read_pipeline_sel = ctrl_q[`ESFB_CTRL_PIPE_A];
assign port_b_read_pipeline_sel = ctrl_q[`ESFB_CTRL_PIPE_B];

// access decode; reset blocks every access
assign a_en = ~port_a_block_enable_n & rst_n;
assign b_en = ~port_b_block_enable_n & rst_n;

// fifo: port a pushes, port b pops; other directions are ignored
assign a_wr = fifo_mode ? push_ok : (a_en & ~port_a_write_select_n);
assign a_rd = ~fifo_mode & a_en & port_a_write_select_n;
assign b_wr = ~fifo_mode & b_en & ~port_b_write_select_n;
assign b_rd = fifo_mode ? pop_ok : (b_en & port_b_write_select_n);

// internal address muxes
assign a_addr_sel = fifo_mode ? fifo_waddr : port_a_addr;
assign b_addr_sel = fifo_mode ? fifo_raddr : port_b_addr;

// fifo requests; ram mode holds the controller in clear
assign push_req = fifo_mode & a_en & ~port_a_write_select_n;
assign pop_req = fifo_mode & b_en & port_b_write_select_n;
assign fifo_clear = clear_q | ~fifo_mode;

////////////////////////////////////////////////////////////////
// hardwired fifo controller, always present
esfb_fifo_ctrl #(
  .AF_MARGIN(AF_MARGIN),
  .AE_MARGIN(AE_MARGIN)
) u_fifo (
  .clk(clk),
  .rst_n(rst_n),
  .clear(fifo_clear),
  .wr_width(write_width_select),
  .rd_width(width_b),
  .push_req(push_req),
  .pop_req(pop_req),
  .push_ok(push_ok),
  .pop_ok(pop_ok),
  .waddr_q(fifo_waddr),
  .raddr_q(fifo_raddr),
  .level_q(fifo_level),
  .full(fifo_full),
  .empty(fifo_empty),
  .almost_full_flag(almost_full_flag),
  .almost_empty_flag(almost_empty_flag)
);

////////////////////////////////////////////////////////////////
// two ports; 18-bit width spans an even and odd word pair
esfb_port u_port_a (
  .clk(clk),
  .rst_n(rst_n),
  .width(write_width_select),
  .pipe_sel(port_a_read_pipeline_sel),
  .addr(a_addr_sel),
  .wdata(port_a_wdata),
  .rd_en(a_rd),
  .rword0(mem_q[a_w0]),
  .rword1(mem_q[a_w1]),
  .word0(a_w0),
  .word1(a_w1),
  .two_words(a_two),
  .mask0(a_m0),
  .data0(a_d0),
  .mask1(a_m1),
  .data1(a_d1),
  .rdata(port_a_rdata)
);

esfb_port u_port_b (
  .clk(clk),
  .rst_n(rst_n),
  .width(width_b),
  .pipe_sel(port_b_read_pipeline_sel),
  .addr(b_addr_sel),
  .wdata(port_b_wdata),
  .rd_en(b_rd),
  .rword0(mem_q[b_w0]),
  .rword1(mem_q[b_w1]),
  .word0(b_w0),
  .word1(b_w1),
  .two_words(b_two),
  .mask0(b_m0),
  .data0(b_d0),
  .mask1(b_m1),
  .data1(b_d1),
  .rdata(port_b_rdata)
);

////////////////////////////////////////////////////////////////
// 512 x 9 array; port b lands last, so on a shared bit it wins
genvar gi;
generate
  for (gi = 0; gi < `ESFB_WORDS; gi = gi + 1) begin : g_word
    localparam [31:0] GI_W = gi;
    localparam [8:0] IDX = GI_W[8:0];
    wire a_hit0;
    wire a_hit1;
    wire b_hit0;
    wire b_hit1;
    wire [8:0] ma;
    wire [8:0] da;
    wire [8:0] mb;
    wire [8:0] db;
    wire [8:0] after_a;
    assign a_hit0 = a_wr && a_w0 == IDX;
    assign a_hit1 = a_wr && a_two && a_w1 == IDX;
    assign b_hit0 = b_wr && b_w0 == IDX;
    assign b_hit1 = b_wr && b_two && b_w1 == IDX;
    assign ma = (a_hit0 ? a_m0 : 9'h000) | (a_hit1 ? a_m1 : 9'h000);
    assign da = (a_hit0 ? a_d0 : 9'h000) | (a_hit1 ? a_d1 : 9'h000);
    assign mb = (b_hit0 ? b_m0 : 9'h000) | (b_hit1 ? b_m1 : 9'h000);
    assign db = (b_hit0 ? b_d0 : 9'h000) | (b_hit1 ? b_d1 : 9'h000);
    assign after_a = (mem_q[IDX] & ~ma) | (da & ma);
    assign mem_d[gi*9 +: 9] = (after_a & ~mb) | (db & mb);
  end
endgenerate

// no reset on the array: contents survive reset
// one clock here, so the reads-before-writes order is fixed for a shared word
always @(posedge clk) begin
  for (k = 0; k < `ESFB_WORDS; k = k + 1) begin
    mem_q[k] <= mem_d[k*9 +: 9];
  end
end

////////////////////////////////////////////////////////////////
// avalon slave: one wait cycle, then the answer
assign bus_req = avs_read | avs_write;
assign bus_take = bus_req & ack_q;
assign avs_waitrequest = bus_req & ~ack_q;
// readdata loads in the wait cycle, so it comes from a flop and stands at the take edge
// costs one bus clock per access, cheaper than a combinational read path
assign rd_load = avs_read & ~ack_q;
assign ctrl_hit = avs_write & bus_take & (avs_address == `ESFB_OFS_CTRL);

////////////////////////////////////////////////////////////////
// read words, built apart from the bus timing
assign ctrl_word = {{(32-`ESFB_CTRL_BITS){1'b0}}, ctrl_q};

always @* begin
  status_word = 32'h00000000;
  status_word[`ESFB_ST_EMPTY] = fifo_empty;
  status_word[`ESFB_ST_FULL] = fifo_full;
  status_word[`ESFB_ST_ALMOST_EMPTY] = almost_empty_flag;
  status_word[`ESFB_ST_ALMOST_FULL] = almost_full_flag;
  status_word[`ESFB_ST_LEVEL_LSB +: 16] = fifo_level;
  ptrs_word = 32'h00000000;
  ptrs_word[`ESFB_PTRS_WR_LSB +: 12] = fifo_waddr;
  ptrs_word[`ESFB_PTRS_RD_LSB +: 12] = fifo_raddr;
end

// unmapped offsets read as zero; status and pointers are read only
always @* begin
  case (avs_address)
    `ESFB_OFS_CTRL: begin
      rd_mux = ctrl_word;
    end
    `ESFB_OFS_STATUS: begin
      rd_mux = status_word;
    end
    `ESFB_OFS_PTRS: begin
      rd_mux = ptrs_word;
    end
    default: begin
      rd_mux = 32'h00000000;
    end
  endcase
end

always @(posedge clk) begin
  if (!rst_n) begin
    ack_q <= 1'b0;
    ctrl_q <= `ESFB_CTRL_RST;
    clear_q <= 1'b0;
    avs_readdata <= 32'h00000000;
  end else begin
    ack_q <= bus_req & ~ack_q;
    clear_q <= 1'b0;
    if (ctrl_hit) begin
      ctrl_q <= avs_writedata[`ESFB_CTRL_BITS-1:0];
      // a mode or width change must restart the pointers
      clear_q <= 1'b1;
    end
    if (rd_load) begin
      avs_readdata <= rd_mux;
    end
  end
end

endmodule // esfb_top
`default_nettype wire

// ===== tb/esfb_user.sv
// user-logic model that drives one memory port of the block
`timescale 1ns/100ps
`default_nettype none
module esfb_user (
  // clock
  input wire logic clk,
  // port drive
  output logic en_n,
  output logic wsel_n,
  output logic [11:0] addr,
  output logic [17:0] wdata
);
  initial begin
    en_n = 1'b1;
    wsel_n = 1'b1;
    addr = 12'h000;
    wdata = 18'h00000;
  end
  // one access per call, both ports on the one shared clock
  task automatic access(input logic wr, input logic [11:0] a, input logic [17:0] d);
    begin
      @(posedge clk);
      en_n <= 1'b0;
      wsel_n <= ~wr;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      // released lines inverted so stale values never pass as live
      en_n <= 1'b1;
      addr <= ~a;
      wdata <= ~d;
    end
  endtask
endmodule // esfb_user
`default_nettype wire

// ===== tb/esfb_top_properties.sv
// concurrent checks on the ports of the sram/fifo block
`timescale 1ns/100ps
`default_nettype none
module esfb_top_chk (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // ports
  input wire logic port_a_block_enable_n,
  input wire logic port_a_write_select_n,
  input wire logic [17:0] port_a_rdata,
  input wire logic port_b_block_enable_n,
  input wire logic port_b_write_select_n,
  input wire logic [17:0] port_b_rdata,
  // flags
  input wire logic fifo_full,
  input wire logic fifo_empty,
  input wire logic almost_full_flag,
  input wire logic almost_empty_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic a_push;
  logic b_pop;
  assign a_push = !port_a_block_enable_n && !port_a_write_select_n;
  assign b_pop = !port_b_block_enable_n && port_b_write_select_n;
  ////////////////////////////////////////////////////////////////////////////////
  first_wait_a: assert property (
    (avs_read || avs_write) && !$past(avs_read || avs_write) |-> avs_waitrequest)
    else $error("no wait state on a new request");
  one_wait_a: assert property (
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request waited more than one cycle");
  reset_flags_a: assert property (
    @(posedge clk) disable iff (1'b0) !rst_n |=> fifo_empty && almost_empty_flag
    && !fifo_full && !almost_full_flag) else $error("flags wrong after reset");
  flag_excl_a: assert property (!(fifo_full && fifo_empty))
    else $error("full and empty together");
  full_alm_a: assert property (fifo_full |-> almost_full_flag)
    else $error("full without almost full");
  empty_alm_a: assert property (fifo_empty |-> almost_empty_flag)
    else $error("empty without almost empty");
  empty_stay_a: assert property (fifo_empty && !a_push |=> fifo_empty)
    else $error("fifo left empty without a push");
  full_stay_a: assert property (
    fifo_full && !b_pop && !avs_write && !$past(avs_write) |=> fifo_full)
    else $error("fifo left full without a pop");
  porta_hold_a: assert property (
    ($past(port_a_block_enable_n) || !$past(port_a_write_select_n)) && $past(rst_n)
    && ($past(port_a_block_enable_n, 2) || !$past(port_a_write_select_n, 2))
    |-> $stable(port_a_rdata)) else $error("port a data moved without a read");
  portb_hold_a: assert property (
    ($past(port_b_block_enable_n) || !$past(port_b_write_select_n)) && $past(rst_n)
    && ($past(port_b_block_enable_n, 2) || !$past(port_b_write_select_n, 2))
    |-> $stable(port_b_rdata)) else $error("port b data moved without a read");
endmodule // esfb_top_chk
`default_nettype wire

// ===== tb/esfb_top_tb.sv
// self-checking testbench of the sram/fifo block
`timescale 1ns/100ps
`default_nettype none
bind esfb_top esfb_top_chk i_chk (.clk(clk), .rst_n(rst_n), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .port_a_block_enable_n(port_a_block_enable_n),
  .port_a_write_select_n(port_a_write_select_n), .port_a_rdata(port_a_rdata),
  .port_b_block_enable_n(port_b_block_enable_n),
  .port_b_write_select_n(port_b_write_select_n), .port_b_rdata(port_b_rdata),
  .fifo_full(fifo_full), .fifo_empty(fifo_empty),
  .almost_full_flag(almost_full_flag), .almost_empty_flag(almost_empty_flag));
module esfb_top_tb;
  logic clk, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic a_en_n, a_wsel_n, b_en_n, b_wsel_n, full, empty, alm_full, alm_empty;
  logic [11:0] a_addr, b_addr;
  logic [17:0] a_wdata, b_wdata, a_rdata, b_rdata;
  integer mismatches = 0;
  integer n_tests = 0;
  esfb_top i_dut (.clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .port_a_block_enable_n(a_en_n), .port_a_write_select_n(a_wsel_n),
    .port_a_addr(a_addr), .port_a_wdata(a_wdata), .port_a_rdata(a_rdata),
    .port_b_block_enable_n(b_en_n), .port_b_write_select_n(b_wsel_n),
    .port_b_addr(b_addr), .port_b_wdata(b_wdata), .port_b_rdata(b_rdata),
    .fifo_full(full), .fifo_empty(empty), .almost_full_flag(alm_full),
    .almost_empty_flag(alm_empty));
  esfb_user i_ua (.clk(clk), .en_n(a_en_n), .wsel_n(a_wsel_n), .addr(a_addr),
    .wdata(a_wdata));
  esfb_user i_ub (.clk(clk), .en_n(b_en_n), .wsel_n(b_wsel_n), .addr(b_addr),
    .wdata(b_wdata));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic final_report;
    begin
      if (mismatches == 0 && n_tests > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
    end
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("BAD t=%0t seen=%h expected=%h", $time, got, exp);
      end
    end
  endtask
  // one avalon cycle; held until waitrequest seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    begin
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      // sampled at the rising edge; only the watchdog ends a wait
      do @(posedge clk);
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
    end
  endtask
  task automatic reset_dut;
    begin
      rst_n <= 1'b0;
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
    end
  endtask
  // flags for a 9-bit fifo holding w words
  function automatic logic [3:0] flags(input integer w);
    flags = {w == 512, w == 0, w * 72 >= 36720, w * 72 <= 144};
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    begin
      av(1'b0, 4'h0, 32'h0, rd); check(rd, 32'h036);
      av(1'b0, 4'h4, 32'h0, rd); check(rd, 32'h5);
      av(1'b1, 4'h8, 32'hFFF, rd);
      av(1'b1, 4'hC, 32'h1, rd);
      av(1'b0, 4'h8, 32'h0, rd); check(rd, 32'h0);
      av(1'b0, 4'hC, 32'h0, rd); check(rd, 32'h0);
      av(1'b0, 4'h0, 32'h0, rd); check(rd, 32'h036);
    end
  endtask
  task automatic t_ram;
    begin
      i_ua.access(1'b1, 12'h005, 18'h1A5);
      i_ub.access(1'b0, 12'h005, 18'h0);
      @(negedge clk); check(b_rdata, 18'h1A5);
      i_ua.access(1'b0, 12'h005, 18'h0);
      @(negedge clk); check(a_rdata, 18'h1A5);
      fork
        i_ua.access(1'b1, 12'h005, 18'h0F0);
        i_ub.access(1'b0, 12'h005, 18'h0);
      join
      @(negedge clk); check(b_rdata, 18'h1A5);
      i_ub.access(1'b1, 12'h005, 18'h033);
      i_ua.access(1'b0, 12'h005, 18'h0);
      @(negedge clk); check(a_rdata, 18'h033);
      av(1'b0, 4'h4, 32'h0, rd); check(rd, 32'h5);
      // array survives reset, output registers do not
      reset_dut;
      @(negedge clk); check(a_rdata, 18'h0);
      i_ua.access(1'b0, 12'h005, 18'h0);
      @(negedge clk); check(a_rdata, 18'h033);
    end
  endtask
  task automatic t_pipe;
    begin
      i_ua.access(1'b1, 12'h007, 18'h055);
      av(1'b1, 4'h0, 32'h136, rd);
      i_ub.access(1'b0, 12'h007, 18'h0);
      @(negedge clk); check(b_rdata, 18'h0);
      @(negedge clk); check(b_rdata, 18'h055);
      av(1'b1, 4'h0, 32'h036, rd);
    end
  endtask
  task automatic t_widths;
    integer c, i, b, n;
    logic [7:0] pat;
    begin
      for (c = 0; c < 3; c = c + 1) begin
        b = 1 << c;
        n = 8 / b;
        pat = 8'h5A + 8'(c * 17);
        av(1'b1, 4'h0, 32'h30 | 32'(c << 1), rd);
        for (i = 0; i < n; i = i + 1)
          i_ua.access(1'b1, 12'((c + 8) * n + i), 18'((pat >> (i * b)) & ((1 << b) - 1)));
        i_ub.access(1'b0, 12'(c + 8), 18'h0);
        @(negedge clk); check(b_rdata[7:0], pat);
      end
      av(1'b1, 4'h0, 32'h38, rd);
      i_ua.access(1'b1, 12'h006, 18'h2B4C7);
      i_ub.access(1'b0, 12'h00C, 18'h0);
      @(negedge clk); check(b_rdata, 18'h0C7);
      i_ub.access(1'b0, 12'h00D, 18'h0);
      @(negedge clk); check(b_rdata, 18'h15A);
      av(1'b1, 4'h0, 32'h26, rd);
      i_ua.access(1'b1, 12'h00E, 18'h1F3);
      i_ub.access(1'b0, 12'h01C, 18'h0);
      @(negedge clk); check(b_rdata[3:0], 4'h3);
      i_ub.access(1'b0, 12'h01D, 18'h0);
      @(negedge clk); check(b_rdata[3:0], 4'hF);
      av(1'b1, 4'h0, 32'h46, rd);
      i_ub.access(1'b0, 12'h006, 18'h0);
      @(negedge clk); check(b_rdata, 18'h2B4C7);
    end
  endtask
  // fill past full and drain past empty; external addresses are junk on purpose
  task automatic t_fifo9;
    integer n;
    begin
      av(1'b1, 4'h0, 32'h37, rd);
      for (n = 1; n <= 513; n = n + 1) begin
        i_ua.access(1'b1, 12'(n * 3), 18'((n * 7) % 512));
        @(negedge clk); check({full, empty, alm_full, alm_empty}, flags(n > 512 ? 512 : n));
      end
      av(1'b0, 4'h4, 32'h0, rd); check(rd, 32'h9000000A);
      for (n = 1; n <= 513; n = n + 1) begin
        i_ub.access(1'b0, 12'(~n), 18'h0);
        @(negedge clk);
        if (n <= 512) check(b_rdata, 18'((n * 7) % 512));
        check({full, empty, alm_full, alm_empty}, flags(n > 512 ? 0 : 512 - n));
      end
    end
  endtask
  task automatic t_conv;
    begin
      av(1'b1, 4'h0, 32'h39, rd);
      i_ua.access(1'b1, 12'h0, 18'h2B4C7);
      av(1'b0, 4'h4, 32'h0, rd); check(rd, 32'h00900004);
      i_ub.access(1'b0, 12'h0, 18'h0);
      @(negedge clk); check(b_rdata, 18'h0C7);
      i_ub.access(1'b0, 12'h0, 18'h0);
      @(negedge clk); check(b_rdata, 18'h15A);
      check(empty, 1'b1);
      av(1'b1, 4'h0, 32'h036, rd);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge clk);
    mismatches = mismatches + 1;
    final_report;
  end
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    reset_dut;
    t_regs;
    t_ram;
    t_pipe;
    t_widths;
    t_fifo9;
    t_conv;
    final_report;
  end
endmodule // esfb_top_tb
`default_nettype wire
